// ===== logic/msc_cfg.svh
// msc_cfg.svh: register offsets, field positions, reset values and timing counts
// assumes a 100 MHz system clock and a 32-bit AHB-Lite register port
`ifndef MSC_CFG_SVH
`define MSC_CFG_SVH

`define MSC_CLK_HZ          100000000
`define MSC_TICK_MS         1
`define MSC_TICK_CYC        ((`MSC_CLK_HZ / 1000) * `MSC_TICK_MS)
`define MSC_PAIR_MIN_MS     150
`define MSC_PAIR_MAX_LO_MS  2000
`define MSC_PAIR_MAX_HI_MS  5000
`define MSC_ENDL_LO_MS      2500
`define MSC_ENDL_HI_MS      6000
`define MSC_BLIND_LO_MS     250
`define MSC_BLIND_HI_MS     1000
`define MSC_TMO_LO_MS       10000

`define MSC_OFS_CTRL        8'h00
`define MSC_OFS_SENS_TIME   8'h04
`define MSC_OFS_TIMEOUT     8'h08
`define MSC_OFS_END_TIME    8'h0C
`define MSC_OFS_BLIND       8'h10
`define MSC_OFS_STATUS      8'h14

`define MSC_CTRL_MODE_LSB   0
`define MSC_CTRL_ENA_BIT    2
`define MSC_CTRL_ENAONLY    3
`define MSC_CTRL_DIR_LSB    4
`define MSC_CTRL_CLOSE_SNS  6
`define MSC_CTRL_BLIND_EN   7
`define MSC_CTRL_MINTIME    8
`define MSC_CTRL_TMO_INF    9
`define MSC_CTRL_RST        32'h0000_0000

`define MSC_SENS_RST        32'h0000_07D0
`define MSC_TMO_RST         32'h0000_2710
`define MSC_END_RST         32'h0000_09C4
`define MSC_BLIND_RST       32'h0000_00FA

`endif

// ===== logic/msc_pkg.sv
// msc_pkg: types for the muting sequence controller
// assumes msc_cfg.svh supplies all numeric constants
package msc_pkg;
  typedef enum logic [1:0] {
    MSC_CONC = 2'b00,
    MSC_L    = 2'b01,
    MSC_SEQ  = 2'b10,
    MSC_T    = 2'b11
  } msc_mode_t;

  typedef enum logic [1:0] {
    MSC_BOTH = 2'b00,
    MSC_UP   = 2'b01,
    MSC_DOWN = 2'b10
  } msc_dir_t;

  typedef enum logic [2:0] {
    MSC_IDLE  = 3'b000,
    MSC_ARM   = 3'b001,
    MSC_PAIR  = 3'b010,
    MSC_SEQ2  = 3'b011,
    MSC_MUTE  = 3'b100,
    MSC_BLIND = 3'b101,
    MSC_WAIT  = 3'b110
  } msc_state_t;

  typedef struct packed {
    logic [3:0] sensor;
    logic       guard;
    logic       enable;
  } msc_in_t;

  // first member is the top bit, so each field sits at its control-word position
  typedef struct packed {
    logic       tmo_inf;
    logic       min_time;
    logic       blind_en;
    logic       close_sensor;
    logic [1:0] dir;
    logic       ena_only;
    logic       ena_used;
    logic [1:0] mode;
  } msc_ctrl_t;
endpackage

// ===== logic/msc_timer.sv
// msc_timer: millisecond counter with clear and expiry compare
// assumes a one-cycle tick enable from the owner's divider
`timescale 1ns/1ps
module msc_timer
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // control
  input  wire logic        tick,
  input  wire logic        clr,
  input  wire logic        run,
  input  wire logic [15:0] limit,
  // status
  output logic      [15:0] count,
  output logic             expired
);
  wire logic at_top = (count == 16'hFFFF);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count <= 16'h0000;
    else if (clr)
      count <= 16'h0000;
    else if (run && tick && !at_top)
      count <= count + 16'h0001;
  end

  assign expired = (count >= limit);
endmodule

// ===== logic/msc_top.sv
// msc_top: muting sequence controller with AHB-Lite register port
// assumes synchronous sensor, guard and enable inputs, single-word bus transfers
// Behaviour
// - bypass the light curtain guard while recognised material passes the opening
// - concurrent mode mutes when sensor_a and sensor_b both interrupt, any order
// - concurrent and sequential start only with all sensors 0 and guard 1
// - L and T start only with sensor_a, sensor_b 0 and guard 1
// - cycle timeout from 10 s to unlimited ends muting at once
// - without enable option the function is always enabled
// - enable/disable arms a cycle only on an enable rising edge
// - enable/disable ends muting at once on enable falling edge
// - enable-only never cancels; enable must return to 0 before rearming
// - concurrent direction selects front-to-rear, rear-to-front or both
// - sequential direction selects ascending, descending or both orders
// - curtain closing ends on guard rise; sensor closing on third sensor clear
// - blind time holds guard as 1 for 250 ms to 1 s after close, except with sensor closing selected
// - pair gap above 2 to 5 s forbids muting in all modes except sequential
// - minimum sensor time needs more than 150 ms between pair activations, except in sequential mode
// - L mode uses only sensor_a, sensor_b; muting ends when opening is freed
// - L end timer 2.5 to 6 s from first release ends muting
// - sequential mutes after a then b, then c and d; reverse is d,c,b,a
// - T mode ends muting when either sensor_a or sensor_b releases
`timescale 1ns/1ps
`include "msc_cfg.svh"
module msc_top
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // field signals
  input  wire logic [3:0]  sensor,
  input  wire logic        light_curtain_guard,
  input  wire logic        mute_enable,
  // outputs
  output logic             guard_out,
  output logic             muting_active
);
  msc_pkg::msc_ctrl_t  ctrl;
  msc_pkg::msc_state_t state;
  msc_pkg::msc_state_t next_state;
  logic [15:0] sens_time;
  logic [15:0] tmo_time;
  logic [15:0] end_time;
  logic [15:0] blind_time;
  logic [16:0] tick_cnt;
  logic        tick;
  logic        ena_q;
  logic        armed;
  logic        dir_rev;
  logic        guard_q;
  logic [3:0]  sens_q;
  logic        rel_seen;
  logic        wr_pend;
  logic [7:0]  wr_addr;

  // bus decode
  wire logic addr_ok = hsel && hready && htrans[1];
  wire logic do_wr   = wr_pend;
  wire logic do_rd   = addr_ok && !hwrite;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl       <= msc_pkg::msc_ctrl_t'(`MSC_CTRL_RST);
      sens_time  <= 16'(`MSC_SENS_RST);
      tmo_time   <= 16'(`MSC_TMO_RST);
      end_time   <= 16'(`MSC_END_RST);
      blind_time <= 16'(`MSC_BLIND_RST);
    end
    else if (do_wr)
    begin
      unique case (wr_addr)
        `MSC_OFS_CTRL:      ctrl <= hwdata[9:0];
        // clamp programmable times to their documented ranges
        `MSC_OFS_SENS_TIME: sens_time <= clamp(hwdata[15:0], 16'(`MSC_PAIR_MAX_LO_MS),
                                               16'(`MSC_PAIR_MAX_HI_MS));
        `MSC_OFS_TIMEOUT:   tmo_time <= (hwdata[15:0] < 16'(`MSC_TMO_LO_MS)) ?
                                        16'(`MSC_TMO_LO_MS) : hwdata[15:0];
        `MSC_OFS_END_TIME:  end_time <= clamp(hwdata[15:0], 16'(`MSC_ENDL_LO_MS),
                                              16'(`MSC_ENDL_HI_MS));
        `MSC_OFS_BLIND:     blind_time <= clamp(hwdata[15:0], 16'(`MSC_BLIND_LO_MS),
                                                16'(`MSC_BLIND_HI_MS));
        default: ;
      endcase
    end
  end

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  wire logic [31:0] status_word = {22'h000000, sens_q, guard_q, muting_active,
                                   armed, state};
  wire logic [31:0] rd_mux =
    (haddr == `MSC_OFS_CTRL)      ? {22'h000000, ctrl} :
    (haddr == `MSC_OFS_SENS_TIME) ? {16'h0000, sens_time} :
    (haddr == `MSC_OFS_TIMEOUT)   ? {16'h0000, tmo_time} :
    (haddr == `MSC_OFS_END_TIME)  ? {16'h0000, end_time} :
    (haddr == `MSC_OFS_BLIND)     ? {16'h0000, blind_time} :
    (haddr == `MSC_OFS_STATUS)    ? status_word : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (do_rd)
      hrdata <= rd_mux;
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // millisecond tick divider
  wire logic tick_wrap = (tick_cnt == 17'(`MSC_TICK_CYC - 1));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_cnt <= 17'h00000;
      tick     <= 1'b0;
    end
    else
    begin
      tick_cnt <= tick_wrap ? 17'h00000 : tick_cnt + 17'h00001;
      tick     <= tick_wrap;
    end
  end

  // input history and enable edges
  wire logic ena_rise = mute_enable && !ena_q;
  wire logic ena_fall = !mute_enable && ena_q;
  wire logic [1:0] mode_w = ctrl.mode;
  wire logic two_sns  = (mode_w == msc_pkg::MSC_L) || (mode_w == msc_pkg::MSC_T);
  wire logic clear_sns = two_sns ? (sens_q[1:0] == 2'b00) : (sens_q == 4'h0);
  wire logic start_ok = clear_sns && guard_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ena_q   <= 1'b0;
      guard_q <= 1'b1;
      sens_q  <= 4'h0;
    end
    else
    begin
      ena_q   <= mute_enable;
      guard_q <= light_curtain_guard;
      sens_q  <= sensor;
    end
  end

  // arming: always when no enable option, else on rising edge
  wire logic cycle_start = (state == msc_pkg::MSC_PAIR) && (next_state == msc_pkg::MSC_MUTE);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      armed <= 1'b0;
    // a new configuration with enable in use waits for a fresh rising edge
    else if (do_wr && (wr_addr == `MSC_OFS_CTRL))
      armed <= !hwdata[`MSC_CTRL_ENA_BIT];
    else if (!ctrl.ena_used)
      armed <= 1'b1;
    else if (ena_rise)
      armed <= 1'b1;
    else if ((ena_fall && !ctrl.ena_only) || cycle_start)
      armed <= 1'b0;
  end

  // front and rear pair views after direction
  wire logic front_any = sens_q[0] || sens_q[1];
  wire logic rear_any  = !two_sns && (sens_q[2] || sens_q[3]);
  wire logic up_ok     = ctrl.dir != msc_pkg::MSC_DOWN;
  wire logic dn_ok     = ctrl.dir != msc_pkg::MSC_UP;
  wire logic [1:0] pair = dir_rev ? {sens_q[2], sens_q[3]} : sens_q[1:0];
  wire logic pair_both = pair == 2'b11;
  wire logic pair_one  = pair != 2'b00;

  // timers
  logic [15:0] gap_cnt;
  logic        gap_over;
  logic        cyc_over;
  logic        aux_over;
  wire logic   gap_clr = state == msc_pkg::MSC_ARM;
  wire logic   aux_clr = (state != next_state);
  wire logic   aux_run = ((state == msc_pkg::MSC_MUTE) && rel_seen) ||
                         (state == msc_pkg::MSC_BLIND);
  wire logic [15:0] aux_lim = (state == msc_pkg::MSC_BLIND) ? blind_time : end_time;

  msc_timer u_gap
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick),
    .clr     (gap_clr),
    .run     (state == msc_pkg::MSC_PAIR),
    .limit   (sens_time),
    .count   (gap_cnt),
    .expired (gap_over)
  );

  msc_timer u_cyc
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick),
    .clr     (gap_clr),
    .run     (state != msc_pkg::MSC_IDLE),
    .limit   (tmo_time),
    .count   (),
    .expired (cyc_over)
  );

  msc_timer u_aux
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick),
    .clr     (aux_clr),
    .run     (aux_run),
    .limit   (aux_lim),
    .count   (),
    .expired (aux_over)
  );

  wire logic min_ok   = !ctrl.min_time || (gap_cnt > 16'(`MSC_PAIR_MIN_MS));
  wire logic tmo_hit  = !ctrl.tmo_inf && cyc_over;
  wire logic kill     = ctrl.ena_used && !ctrl.ena_only && ena_fall;

  // sequential: second sensor of the first pair must follow the first
  wire logic seq_mode = mode_w == msc_pkg::MSC_SEQ;
  wire logic [1:0] far_pair = dir_rev ? sens_q[1:0] : {sens_q[2], sens_q[3]};
  // pair[0] is the first sensor of the running order in either direction
  wire logic seq_a_first = pair[0];
  wire logic third_clr = dir_rev ? !sens_q[1] : !sens_q[2];
  wire logic closed_curtain = guard_q;

  // closing condition per mode
  logic close_now;
  always_comb
  begin
    close_now = 1'b0;
    unique case (mode_w)
      msc_pkg::MSC_T: close_now = sens_q[1:0] != 2'b11;
      msc_pkg::MSC_L: close_now = (rel_seen && !front_any && guard_q) ||
                                  (rel_seen && aux_over);
      default:
        if (ctrl.close_sensor)
          close_now = (far_pair != 2'b00) && pair == 2'b00 && third_clr;
        else
          close_now = (far_pair != 2'b00 || pair == 2'b00) && pair == 2'b00 &&
                      closed_curtain;
    endcase
  end

  always_comb
  begin
    next_state = state;
    unique case (state)
      msc_pkg::MSC_IDLE:
        if (armed && start_ok)
          next_state = msc_pkg::MSC_ARM;
      msc_pkg::MSC_ARM:
        if (!armed)
          next_state = msc_pkg::MSC_IDLE;
        else if (front_any && up_ok)
          next_state = msc_pkg::MSC_PAIR;
        else if (rear_any && dn_ok)
          next_state = msc_pkg::MSC_PAIR;
      msc_pkg::MSC_PAIR:
        if (kill || tmo_hit)
          next_state = msc_pkg::MSC_WAIT;
        else if (seq_mode ? (pair[1] && !seq_a_first) : gap_over)
          next_state = msc_pkg::MSC_WAIT;
        else if (!pair_one)
          next_state = msc_pkg::MSC_WAIT;
        else if (pair_both && (seq_mode || min_ok))
          next_state = msc_pkg::MSC_MUTE;
      msc_pkg::MSC_MUTE:
        if (kill || tmo_hit)
          next_state = msc_pkg::MSC_WAIT;
        else if (close_now)
          next_state = (ctrl.blind_en && !ctrl.close_sensor) ? msc_pkg::MSC_BLIND
                                                              : msc_pkg::MSC_WAIT;
      msc_pkg::MSC_BLIND:
        if (aux_over)
          next_state = msc_pkg::MSC_WAIT;
      msc_pkg::MSC_WAIT:
        next_state = msc_pkg::MSC_IDLE;
      default:
        next_state = msc_pkg::MSC_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state    <= msc_pkg::MSC_IDLE;
      dir_rev  <= 1'b0;
      rel_seen <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == msc_pkg::MSC_ARM)
        dir_rev <= !(front_any && up_ok);
      if (state != msc_pkg::MSC_MUTE)
        rel_seen <= 1'b0;
      else if (sens_q[1:0] != 2'b11)
        rel_seen <= 1'b1;
    end
  end

  // outputs: muted or blind holds guard at 1
  wire logic next_mute = (next_state == msc_pkg::MSC_MUTE) ||
                         (next_state == msc_pkg::MSC_BLIND);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      muting_active <= 1'b0;
      guard_out     <= 1'b0;
    end
    else
    begin
      muting_active <= next_state == msc_pkg::MSC_MUTE;
      guard_out     <= next_mute || light_curtain_guard;
    end
  end
endmodule

// ===== bench/msc_checker.sv
// msc_checker: port-level assertions for msc_top
// assumes one ahb-lite slave whose hreadyout is the bus hready
`timescale 1ns/1ps
module msc_checker
(
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // field
  input wire logic [3:0]  sensor,
  input wire logic        light_curtain_guard,
  input wire logic        mute_enable,
  input wire logic        guard_out,
  input wire logic        muting_active
);
  logic       wr_ctl;
  logic [9:0] ctl;
  wire        take    = hsel & hready & htrans[1];
  wire        t_mode  = ctl[1:0] == 2'h3;
  wire        ena_dis = ctl[2] & ~ctl[3];
  wire        curtain = ~ctl[0] & ~ctl[6];

  // shadow of the control word, taken from bus writes
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wr_ctl <= 1'b0;
    else
      wr_ctl <= take & hwrite & (haddr == 8'h00);
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      ctl <= 10'h000;
    else if (wr_ctl)
      ctl <= hwdata[9:0];

  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence pair_seen;
    $past(sensor[1:0], 2) == 2'h3 || $past(sensor[3:2], 2) == 2'h3;
  endsequence
  sequence mute_gone;
    ##[1:3] !muting_active;
  endsequence

  ready_always_a: assert property (hreadyout)
    else $error("hreadyout low");
  resp_okay_a: assert property (!hresp)
    else $error("hresp not okay");
  unmapped_read_a: assert property (take && !hwrite && haddr > 8'h14 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  mute_holds_a: assert property (muting_active |-> guard_out)
    else $error("guard output low while muting");
  guard_pass_a: assert property (light_curtain_guard [*3] |-> guard_out)
    else $error("clear curtain not passed");
  guard_block_a: assert property ((!light_curtain_guard && !muting_active && !ctl[7]) [*3]
    |-> !guard_out)
    else $error("blocked curtain not passed");
  mute_cause_a: assert property ($rose(muting_active) |-> pair_seen)
    else $error("muting without a sensor pair");
  t_release_a: assert property (t_mode && muting_active && sensor[1:0] != 2'h3
    |-> mute_gone)
    else $error("muting kept after release");
  ena_fall_a: assert property (ena_dis && $fell(mute_enable) |-> mute_gone)
    else $error("muting kept after enable fall");
  curtain_close_a: assert property (curtain && muting_active && $rose(light_curtain_guard)
    |-> mute_gone)
    else $error("muting kept after curtain rise");
endmodule

bind msc_top msc_checker chk_i
(
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .hreadyout, .hresp, .sensor, .light_curtain_guard, .mute_enable, .guard_out,
  .muting_active
);

// ===== bench/msc_field.sv
// msc_field: muting beams, light curtain and enable switch
// assumes the bench commands every line level through a packed struct
`timescale 1ns/1ps
module msc_field
(
  // clock
  input  wire logic             hclk,
  // wanted line levels
  input  wire msc_pkg::msc_in_t cmd,
  // lines towards the block
  output msc_pkg::msc_in_t      fld
);
  // lines move just after an edge, as a synchronised field input would
  always @(posedge hclk)
  begin
    fld.sensor <= cmd.sensor;
    fld.guard  <= cmd.guard;
    fld.enable <= cmd.enable;
  end
endmodule

// ===== bench/tb_muting_sequence_controller.sv
// tb_muting_sequence_controller: register and muting sequence tests
// assumes msc_top, msc_field and the bound checker
`timescale 1ns/1ps
`include "msc_cfg.svh"
module tb_muting_sequence_controller;
  logic             hclk;
  logic             hresetn;
  logic             hsel;
  logic [7:0]       haddr;
  logic [1:0]       htrans;
  logic             hwrite;
  logic [2:0]       hsize;
  logic [31:0]      hwdata;
  logic [31:0]      hrdata;
  logic [31:0]      q;
  logic             hreadyout;
  logic             hresp;
  logic             guard_out;
  logic             muting_active;
  msc_pkg::msc_in_t cmd;
  msc_pkg::msc_in_t fld;
  int               err_total;
  int               n_compared;
  int               i;
  logic [7:0]       ra [6] = '{`MSC_OFS_CTRL, `MSC_OFS_SENS_TIME, `MSC_OFS_TIMEOUT,
                               `MSC_OFS_END_TIME, `MSC_OFS_BLIND, 8'h18};
  logic [31:0]      rv [6] = '{`MSC_CTRL_RST, `MSC_SENS_RST, `MSC_TMO_RST,
                               `MSC_END_RST, `MSC_BLIND_RST, 32'h0};
  logic [31:0]      cm [4] = '{32'h0, 32'h2, 32'h40, 32'h42};
  logic [31:0]      dc [2] = '{32'h10, 32'h22};
  logic [3:0]       df [2] = '{4'h8, 4'h1};
  logic [3:0]       dp [2] = '{4'hC, 4'h3};
  logic [31:0]      lo [4] = '{`MSC_PAIR_MAX_LO_MS, `MSC_TMO_LO_MS, `MSC_ENDL_LO_MS,
                               `MSC_BLIND_LO_MS};
  logic [31:0]      hi [4] = '{`MSC_PAIR_MAX_HI_MS, 32'h0000_FFFF, `MSC_ENDL_HI_MS,
                               `MSC_BLIND_HI_MS};

  msc_field far
  (
    .hclk (hclk),
    .cmd  (cmd),
    .fld  (fld)
  );

  msc_top uut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sensor(fld.sensor),
    .light_curtain_guard(fld.guard), .mute_enable(fld.enable),
    .guard_out(guard_out), .muting_active(muting_active)
  );

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do
      @(posedge hclk);
    while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do
      @(posedge hclk);
    while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  // one field step: set the lines, let them settle, check both outputs
  task automatic st(input logic [3:0] s, input logic g, input logic e, input logic m);
    cmd <= '{s, g, e};
    repeat (8)
      @(posedge hclk);
    chk({31'h0, muting_active}, {31'h0, m});
    chk({31'h0, guard_out}, {31'h0, m | g});
  endtask

  task automatic end_of_test;
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000)
      @(posedge hclk);
    err_total++;
    end_of_test;
  end

  initial
  begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cmd = '{4'h0, 1'b1, 1'b0};
    err_total = 0;
    n_compared = 0;
    hresetn = 1'b0;
    repeat (12)
      @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b1, 8'h18, 32'hFFFF_FFFF);
    for (i = 0; i < 6; i++)
    begin
      bus(1'b0, ra[i], 32'h0);
      chk(q, rv[i]);
    end
    // programmable times are held inside their ranges
    for (i = 0; i < 4; i++)
    begin
      bus(1'b1, ra[i + 1], 32'h0);
      bus(1'b0, ra[i + 1], 32'h0);
      chk(q, lo[i]);
      bus(1'b1, ra[i + 1], 32'hFFFF);
      bus(1'b0, ra[i + 1], 32'h0);
      chk(q, hi[i]);
    end
    bus(1'b1, `MSC_OFS_CTRL, 32'hFFFF_FFFF);
    bus(1'b0, `MSC_OFS_CTRL, 32'h0);
    chk(q, 32'h0000_03FF);
    // concurrent and sequential, curtain and sensor closing, no enable
    for (i = 0; i < 4; i++)
    begin
      bus(1'b1, `MSC_OFS_CTRL, cm[i]);
      st(4'h0, 1, 0, 0);
      st(4'h1, 1, 0, 0);
      st(4'h3, 1, 0, 1);
      st(4'h3, 0, 0, 1);
      st(4'h7, 0, 0, 1);
      st(4'hF, 0, 0, 1);
      st(4'hE, 0, 0, 1);
      st(4'hC, 0, 0, 1);
      st(4'hC, 1, 0, cm[i][6]);
      st(4'h8, 1, 0, 0);
      st(4'h0, 1, 0, 0);
    end
    // start refused while the opening is not clear
    bus(1'b1, `MSC_OFS_CTRL, 32'h0);
    st(4'h4, 1, 0, 0);
    st(4'h7, 1, 0, 0);
    st(4'h0, 0, 0, 0);
    st(4'h3, 0, 0, 0);
    // direction limits
    for (i = 0; i < 2; i++)
    begin
      bus(1'b1, `MSC_OFS_CTRL, dc[i]);
      st(4'h0, 1, 0, 0);
      st(df[i], 1, 0, 0);
      st(dp[i], 1, 0, 0);
    end
    // L mode ignores the rear pair, T mode ends on one release
    bus(1'b1, `MSC_OFS_CTRL, 32'h1);
    st(4'h0, 1, 0, 0);
    st(4'hC, 1, 0, 0);
    st(4'hF, 1, 0, 1);
    st(4'h0, 1, 0, 0);
    bus(1'b1, `MSC_OFS_CTRL, 32'h3);
    st(4'h3, 1, 0, 1);
    st(4'h2, 1, 0, 0);
    st(4'h0, 1, 0, 0);
    // enable and disable
    bus(1'b1, `MSC_OFS_CTRL, 32'h4);
    st(4'h3, 1, 0, 0);
    st(4'h0, 1, 0, 0);
    st(4'h0, 1, 1, 0);
    st(4'h3, 1, 1, 1);
    st(4'h3, 1, 0, 0);
    st(4'h0, 1, 0, 0);
    st(4'h0, 1, 1, 0);
    st(4'h3, 1, 1, 1);
    st(4'hC, 0, 1, 1);
    st(4'hC, 1, 1, 0);
    st(4'h0, 1, 1, 0);
    st(4'h3, 1, 1, 0);
    st(4'h0, 1, 0, 0);
    // enable only: dropping enable keeps the cycle
    bus(1'b1, `MSC_OFS_CTRL, 32'hC);
    st(4'h0, 1, 1, 0);
    st(4'h3, 1, 1, 1);
    st(4'h3, 1, 0, 1);
    st(4'hC, 0, 0, 1);
    st(4'hC, 1, 0, 0);
    st(4'h0, 1, 0, 0);
    // idle, disarmed, curtain clear, no sensor
    bus(1'b0, `MSC_OFS_STATUS, 32'h0);
    chk(q, 32'h0000_0020);
    end_of_test;
  end
endmodule
